// >>> verilog/tci_defines.svh
// named constants for the cycle timing and interlock block
`ifndef TCI_DEFINES_SVH
`define TCI_DEFINES_SVH

// ==========================================================================
// widths and the pc register number
`define TCI_CNT_W        6
`define TCI_PC_REG       4'hf

// ==========================================================================
// cycle counts, all at counter width
`define TCI_ONE          6'h01
`define TCI_DP_BASE      6'h01
`define TCI_RSHIFT_CYC   6'h01
`define TCI_REFILL_CYC   6'h02
`define TCI_PC_LOAD_POST 6'h04
`define TCI_WORD_ILK     6'h01
`define TCI_ROT_ILK      6'h02
`define TCI_LDM1_POST    6'h01
`define TCI_STM1_POST    6'h01
`define TCI_LAST_ILK     6'h01
`define TCI_SWP_ACC      6'h02
`define TCI_SWP_ILK      6'h01
`define TCI_CDP_PRE      6'h01
`define TCI_MRC_USE_ILK  6'h01
`define TCI_MRC_PC_PRE   6'h02
`define TCI_MSR_FLAG_CYC 6'h01
`define TCI_MSR_FULL_CYC 6'h03
`define TCI_MUL32_BASE   6'h02
`define TCI_MULL_BASE    6'h03

// ==========================================================================
// early termination boundaries and counts
`define TCI_MT_B1        8
`define TCI_MT_B2        16
`define TCI_MT_B3        24
`define TCI_M1           3'h1
`define TCI_M2           3'h2
`define TCI_M3           3'h3
`define TCI_M4           3'h4

`endif

// >>> verilog/tci_pkg.sv
// types shared by the cycle timing and interlock block
`include "tci_defines.svh"

package tci_pkg;

	// ======================================================================
	// instruction classes and bus cycle kinds
	typedef enum logic [3:0] {
		CLS_DATA_OP,
		CLS_SINGLE_LOAD,
		CLS_SINGLE_STORE,
		CLS_LOAD_MULTIPLE,
		CLS_STORE_MULTIPLE,
		CLS_ATOMIC_SWAP,
		CLS_COPROC_DATA_OP,
		CLS_COPROC_LOAD_STORE,
		CLS_CORE_TO_COPROC_MOVE,
		CLS_COPROC_TO_CORE_MOVE,
		CLS_STATUS_REG_WRITE,
		CLS_MULTIPLY_32,
		CLS_LONG_MULTIPLY
	} tci_class_e;

	typedef enum logic [1:0] {
		CYC_I,
		CYC_S,
		CYC_N,
		CYC_C
	} tci_cyc_e;

	typedef logic [`TCI_CNT_W-1:0] tci_cnt_t;

	// ======================================================================
	// whole state of the sequencer
	typedef struct packed {
		logic       active;
		logic       wait_cp;
		logic       first;
		tci_class_e cls;
		tci_cnt_t   idx;
		tci_cnt_t   pre;
		tci_cnt_t   acc;
		tci_cnt_t   post;
		tci_cnt_t   ilk_at;
		tci_cnt_t   ilk;
		logic       refill;
		tci_cyc_e   acc_first;
		tci_cyc_e   acc_rest;
		logic [15:0] rem;
		tci_cyc_e   ibus;
		tci_cyc_e   dbus;
		logic       stall;
		logic       xval;
		logic [3:0] xreg;
		logic       done;
	} tci_state_s;

	// index of the lowest set bit, zero for an empty mask
	function automatic logic [3:0] tci_lowest(input logic [15:0] mask);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 15; i >= 0; i--)
		begin
			if (mask[i])
				r = 4'(i);
		end
		return r;
	endfunction : tci_lowest

endpackage : tci_pkg

// >>> verilog/tci_mul_term.sv
// early termination count of the multiplier operand
`timescale 1ns/1ns
`include "tci_defines.svh"

module tci_mul_term (
	input  wire logic [31:0] operand_i,   // multiplier operand value
	input  wire logic        unsigned_i,  // unsigned long multiply
	output logic      [2:0]  m_o          // iterations, 1 to 4
);
	import tci_pkg::*;

	// signed forms accept all ones as well as all zeros
	function automatic logic top_same(input logic [31:0] v, input int lo, input logic uns);
		logic z;
		logic o;
		z = 1'b1;
		o = 1'b1;
		for (int i = 31; i >= 0; i--)
		begin
			if (i >= lo)
			begin
				z = z & ~v[i];
				o = o & v[i];
			end
		end
		return z | (o & ~uns);
	endfunction : top_same

	always_comb
	begin
		if (top_same(operand_i, `TCI_MT_B1, unsigned_i))
			m_o = `TCI_M1;
		else if (top_same(operand_i, `TCI_MT_B2, unsigned_i))
			m_o = `TCI_M2;
		else if (top_same(operand_i, `TCI_MT_B3, unsigned_i))
			m_o = `TCI_M3;
		else
			m_o = `TCI_M4;
	end

endmodule : tci_mul_term

// >>> verilog/tci_reg_scan.sv
// register list scan: count of registers and highest one named
`timescale 1ns/1ns

module tci_reg_scan (
	input  wire logic [15:0] list_i,   // register list, bit per register
	output logic      [4:0]  count_o,  // number of registers named
	output logic      [3:0]  high_o    // highest register number named
);
	always_comb
	begin
		count_o = 5'h00;
		high_o  = 4'h0;
		for (int i = 0; i < 16; i++)
		begin
			if (list_i[i])
			begin
				count_o = 5'(count_o + 5'h01);
				high_o  = 4'(i);
			end
		end
	end

endmodule : tci_reg_scan

// >>> verilog/tci_core.sv
// cycle timing and interlock sequencer for the five-stage core
`timescale 1ns/1ns
`include "tci_defines.svh"

module tci_core (
	input  wire logic                clk_i,          // core clock, 250 MHz
	input  wire logic                rst_b_i,        // asynchronous reset, active low
	input  wire logic                issue_valid_i,  // instruction offered to execute
	output logic                     issue_ready_o,  // instruction can be taken this cycle
	input  wire tci_pkg::tci_class_e iclass_i,       // instruction class
	input  wire logic                pc_dest_i,      // writes the program counter
	input  wire logic                reg_shift_i,    // shift amount from a register
	input  wire logic                subword_i,      // byte, halfword or unaligned load
	input  wire logic                flags_only_i,   // status write touches flags only
	input  wire logic                unsigned_i,     // unsigned long multiply
	input  wire logic                narrow_enc_i,   // 16-bit multiply encoding
	input  wire logic [31:0]         instr_i,        // instruction encoding
	input  wire logic [15:0]         reg_list_i,     // load/store multiple register list
	input  wire logic [4:0]          cp_words_i,     // coprocessor transfer words
	input  wire logic                next_uses_i,    // next instruction uses the result
	input  wire logic [15:0]         next_src_i,     // registers the next instruction reads
	input  wire logic                cp_busy_i,      // coprocessor busy-wait
	output logic      [3:0]          mul_rs_o,       // multiplier operand register
	input  wire logic [31:0]         mul_operand_i,  // value of that register
	output tci_pkg::tci_cyc_e        ibus_o,         // instruction bus cycle kind
	output tci_pkg::tci_cyc_e        dbus_o,         // data bus cycle kind
	output logic                     fetch_stall_o,  // interlock, fetches halted
	output logic                     xfer_valid_o,   // multiple transfer active
	output logic      [3:0]          xfer_reg_o,     // register of this transfer
	output logic                     done_o,         // final cycle of instruction
	output logic                     busy_o          // instruction in progress
);
	import tci_pkg::*;

	// ======================================================================
	// operand scans
	tci_state_s s_r;
	tci_state_s s_nxt;
	logic [2:0] m_val;
	logic [4:0] list_cnt;
	logic [3:0] list_high;
	tci_cnt_t   nregs;
	tci_cnt_t   mul_m;
	tci_cnt_t   len_c;
	tci_cnt_t   len_n;
	logic       accept;
	logic       cpw;
	logic       in_acc_c;
	logic       in_acc_n;
	logic       main_n;

	assign mul_rs_o = narrow_enc_i ? {1'b0, instr_i[2:0]} : instr_i[11:8];

	tci_mul_term u_mul_term (
		.operand_i  (mul_operand_i),
		.unsigned_i (unsigned_i & (iclass_i == CLS_LONG_MULTIPLY)),
		.m_o        (m_val)
	);

	tci_reg_scan u_reg_scan (
		.list_i  (reg_list_i),
		.count_o (list_cnt),
		.high_o  (list_high)
	);

	// an empty list cannot be issued; treat as one so lengths never reach zero
	assign nregs = (list_cnt == 5'h00) ? `TCI_ONE : tci_cnt_t'(list_cnt);
	assign mul_m = tci_cnt_t'(m_val);

	// ======================================================================
	// issue handshake
	// the next instruction enters during the final cycle; for a load multiple of two or more registers, pc not among them, a dependant
	// on the last register gets one interlock cycle after the final access
	assign issue_ready_o = !s_r.active || s_r.done;
	assign accept        = issue_valid_i && issue_ready_o;

	assign len_c    = tci_cnt_t'(s_r.pre + s_r.acc + s_r.post);
	assign in_acc_c = !s_r.wait_cp && (s_r.idx >= s_r.pre) &&
		(s_r.idx < tci_cnt_t'(s_r.pre + s_r.acc));

	// ======================================================================
	// sequencer
	always_comb
	begin
		s_nxt = s_r;
		cpw   = 1'b0;
		if (accept)
		begin
			s_nxt           = '0;
			s_nxt.active    = 1'b1;
			s_nxt.first     = 1'b1;
			s_nxt.cls       = iclass_i;
			s_nxt.rem       = reg_list_i;
			s_nxt.acc_first = CYC_N;
			s_nxt.acc_rest  = CYC_S;
			unique case (iclass_i)
				CLS_DATA_OP:
				begin
					s_nxt.pre = `TCI_DP_BASE;
					if (reg_shift_i)
						s_nxt.pre = tci_cnt_t'(s_nxt.pre + `TCI_RSHIFT_CYC);
					if (pc_dest_i)
						s_nxt.pre = tci_cnt_t'(s_nxt.pre + `TCI_REFILL_CYC);
					s_nxt.refill = pc_dest_i;
				end
				CLS_SINGLE_LOAD:
				begin
					s_nxt.acc = `TCI_ONE;
					if (pc_dest_i)
					begin
						s_nxt.post   = `TCI_PC_LOAD_POST;
						s_nxt.refill = 1'b1;
					end
					else if (next_uses_i)
					begin
						s_nxt.post   = subword_i ? `TCI_ROT_ILK : `TCI_WORD_ILK;
						s_nxt.ilk_at = `TCI_ONE;
						s_nxt.ilk    = s_nxt.post;
					end
				end
				CLS_SINGLE_STORE:
					s_nxt.acc = `TCI_ONE;
				CLS_LOAD_MULTIPLE:
				begin
					s_nxt.acc = nregs;
					if (reg_list_i[`TCI_PC_REG])
					begin
						s_nxt.post   = `TCI_PC_LOAD_POST;
						s_nxt.refill = 1'b1;
					end
					else if (nregs == `TCI_ONE)
					begin
						s_nxt.acc_first = CYC_S;
						s_nxt.post      = `TCI_LDM1_POST;
					end
					else if (next_src_i[list_high])
					begin
						s_nxt.post   = `TCI_LAST_ILK;
						s_nxt.ilk_at = nregs;
						s_nxt.ilk    = `TCI_LAST_ILK;
					end
				end
				CLS_STORE_MULTIPLE:
				begin
					s_nxt.acc = nregs;
					if (nregs == `TCI_ONE)
						s_nxt.post = `TCI_STM1_POST;
				end
				CLS_ATOMIC_SWAP:
				begin
					s_nxt.acc      = `TCI_SWP_ACC;
					s_nxt.acc_rest = CYC_N;
					if (next_uses_i)
					begin
						s_nxt.post   = `TCI_SWP_ILK;
						s_nxt.ilk_at = `TCI_SWP_ACC;
						s_nxt.ilk    = `TCI_SWP_ILK;
					end
				end
				CLS_COPROC_DATA_OP:
				begin
					cpw       = 1'b1;
					s_nxt.pre = `TCI_CDP_PRE;
				end
				CLS_COPROC_LOAD_STORE:
				begin
					cpw       = 1'b1;
					s_nxt.acc = (cp_words_i == 5'h00) ? `TCI_ONE : tci_cnt_t'(cp_words_i);
				end
				CLS_CORE_TO_COPROC_MOVE:
				begin
					cpw             = 1'b1;
					s_nxt.acc       = `TCI_ONE;
					s_nxt.acc_first = CYC_C;
				end
				CLS_COPROC_TO_CORE_MOVE:
				begin
					cpw             = 1'b1;
					s_nxt.acc       = `TCI_ONE;
					s_nxt.acc_first = CYC_C;
					if (pc_dest_i)
						s_nxt.pre = `TCI_MRC_PC_PRE;
					else if (next_uses_i)
						s_nxt.pre = `TCI_MRC_USE_ILK;
					s_nxt.ilk = s_nxt.pre;
				end
				CLS_STATUS_REG_WRITE:
					s_nxt.pre = flags_only_i ? `TCI_MSR_FLAG_CYC : `TCI_MSR_FULL_CYC;
				CLS_MULTIPLY_32:
					s_nxt.pre = tci_cnt_t'(`TCI_MUL32_BASE + mul_m);
				CLS_LONG_MULTIPLY:
					s_nxt.pre = tci_cnt_t'(`TCI_MULL_BASE + mul_m);
				// unused class codes run as a single internal cycle so the core never hangs
				default:
					s_nxt.pre = `TCI_ONE;
			endcase
			// b is the run of busy cycles from issue; each adds one I cycle
			s_nxt.wait_cp = cpw && cp_busy_i;
		end
		else if (s_r.active)
		begin
			s_nxt.first = 1'b0;
			if (s_r.wait_cp)
			begin
				if (!cp_busy_i)
					s_nxt.wait_cp = 1'b0;
			end
			else if (s_r.done)
				s_nxt.active = 1'b0;
			else
			begin
				s_nxt.idx = tci_cnt_t'(s_r.idx + `TCI_ONE);
				if (in_acc_c)
					s_nxt.rem = s_r.rem & ~(16'h0001 << tci_lowest(s_r.rem));
			end
		end

		// bus kinds for the cycle that the next state stands for
		len_n    = tci_cnt_t'(s_nxt.pre + s_nxt.acc + s_nxt.post);
		main_n   = s_nxt.active && !s_nxt.wait_cp;
		in_acc_n = main_n && (s_nxt.idx >= s_nxt.pre) &&
			(s_nxt.idx < tci_cnt_t'(s_nxt.pre + s_nxt.acc));
		if (in_acc_n)
			s_nxt.dbus = (s_nxt.idx == s_nxt.pre) ? s_nxt.acc_first : s_nxt.acc_rest;
		else
			s_nxt.dbus = CYC_I;
		if (s_nxt.active && s_nxt.first)
			s_nxt.ibus = CYC_S;
		else if (main_n && s_nxt.refill && s_nxt.idx == tci_cnt_t'(len_n - `TCI_REFILL_CYC))
			s_nxt.ibus = CYC_N;
		else if (main_n && s_nxt.refill && s_nxt.idx == tci_cnt_t'(len_n - `TCI_ONE))
			s_nxt.ibus = CYC_S;
		else
			s_nxt.ibus = CYC_I;
		s_nxt.stall = main_n && (s_nxt.idx >= s_nxt.ilk_at) &&
			(s_nxt.idx < tci_cnt_t'(s_nxt.ilk_at + s_nxt.ilk));
		s_nxt.xval  = in_acc_n &&
			(s_nxt.cls == CLS_LOAD_MULTIPLE || s_nxt.cls == CLS_STORE_MULTIPLE);
		s_nxt.xreg  = tci_lowest(s_nxt.rem);
		s_nxt.done  = main_n && (s_nxt.idx == tci_cnt_t'(len_n - `TCI_ONE));
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	// ======================================================================
	// outputs
	assign ibus_o        = s_r.ibus;
	assign dbus_o        = s_r.dbus;
	assign fetch_stall_o = s_r.stall;
	assign xfer_valid_o  = s_r.xval;
	assign xfer_reg_o    = s_r.xreg;
	assign done_o        = s_r.done;
	assign busy_o        = s_r.active;

	// len_c is kept for readability of the access window
	logic unused_len;
	assign unused_len = |len_c;

endmodule : tci_core

// >>> tb/tci_far_model.sv
// far side model: coprocessor busy-wait and the register file read by the multiplier
`timescale 1ns/1ns

module tci_far_model (
	input  wire logic        clk_i,         // core clock
	input  wire logic        rst_b_i,       // reset, active low
	input  wire logic        arm_i,         // instruction offered
	input  wire logic [3:0]  b_i,           // busy-wait states to give
	input  wire logic [3:0]  mul_rs_i,      // register asked for
	output logic             cp_busy_o,     // coprocessor busy
	output logic      [31:0] mul_operand_o  // value of that register
);
	// ======================================================================
	// busy-wait
	logic [3:0] left_r;

	// busy shows in the offer cycle already, so the core sees it on accept
	assign cp_busy_o = arm_i ? (b_i != 4'h0) : (left_r != 4'h0);
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			left_r <= 4'h0;
		else if (arm_i && b_i != 4'h0)
			left_r <= b_i - 4'h1;
		else if (left_r != 4'h0)
			left_r <= left_r - 4'h1;
	end

	// ======================================================================
	// register file, values chosen to give each early termination count
	localparam logic [31:0] RF [8] = '{32'h00000012, 32'hffffff80, 32'h00001234, 32'h00abcdef,
		32'h12345678, 32'hffff8000, 32'h7fffffff, 32'h80000000};
	assign mul_operand_o = RF[mul_rs_i[2:0]];
endmodule : tci_far_model

// >>> tb/tci_core_properties.sv
// concurrent checks on the ports of the sequencer
`timescale 1ns/1ns

module tci_core_properties (
	input wire logic                clk_i,          // clock
	input wire logic                rst_b_i,        // reset
	input wire logic                issue_valid_i,  // offer
	input wire logic                issue_ready_o,  // taken
	input wire tci_pkg::tci_class_e iclass_i,       // class
	input wire logic                pc_dest_i,      // writes pc
	input wire logic                reg_shift_i,    // register shift
	input wire logic                subword_i,      // subword load
	input wire logic                next_uses_i,    // result used next
	input wire logic                unsigned_i,     // unsigned long
	input wire logic                narrow_enc_i,   // short encoding
	input wire logic [31:0]         instr_i,        // encoding
	input wire logic [3:0]          mul_rs_o,       // operand register
	input wire logic [31:0]         mul_operand_i,  // operand value
	input wire tci_pkg::tci_cyc_e   ibus_o,         // fetch cycle
	input wire tci_pkg::tci_cyc_e   dbus_o,         // data cycle
	input wire logic                fetch_stall_o,  // interlock
	input wire logic                xfer_valid_o,   // transfer
	input wire logic [3:0]          xfer_reg_o,     // transfer register
	input wire logic                done_o          // last cycle
);
	import tci_pkg::*;
	logic       acc, dop, ld, mul_r;
	logic [2:0] exp_r, idx_r;

	assign acc = issue_valid_i & issue_ready_o;
	assign dop = acc && iclass_i == CLS_DATA_OP;
	assign ld  = acc && iclass_i == CLS_SINGLE_LOAD;

	function automatic logic [2:0] em(input logic [31:0] x, input logic u);
		if (u ? ~|x[31:8] : (~|x[31:8] || &x[31:8]))
			return 3'h1;
		if (u ? ~|x[31:16] : (~|x[31:16] || &x[31:16]))
			return 3'h2;
		if (u ? ~|x[31:24] : (~|x[31:24] || &x[31:24]))
			return 3'h3;
		return 3'h4;
	endfunction : em

	// cycle index inside a multiply, held against the count expected at accept
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			mul_r <= 1'b0;
			exp_r <= 3'h0;
			idx_r <= 3'h0;
		end
		else if (acc)
		begin
			mul_r <= iclass_i == CLS_MULTIPLY_32 || iclass_i == CLS_LONG_MULTIPLY;
			exp_r <= em(mul_operand_i, unsigned_i && iclass_i == CLS_LONG_MULTIPLY)
				+ ((iclass_i == CLS_LONG_MULTIPLY) ? 3'h2 : 3'h1);
			idx_r <= 3'h0;
		end
		else
			idx_r <= idx_r + 3'h1;
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	plain_op_a: assert property (dop && !pc_dest_i && !reg_shift_i
		|=> done_o && ibus_o == CYC_S && dbus_o == CYC_I) else $error("plain data op not one cycle");
	pc_op_a: assert property (dop && pc_dest_i && !reg_shift_i
		|=> ibus_o == CYC_S ##1 ibus_o == CYC_N ##1 ibus_o == CYC_S && done_o) else $error("pc data op refill wrong");
	sub_use_a: assert property (ld && !pc_dest_i && subword_i && next_uses_i
		|=> !fetch_stall_o ##1 fetch_stall_o ##1 fetch_stall_o && done_o) else $error("subword interlock wrong");
	load_pc_a: assert property (ld && pc_dest_i
		|=> dbus_o == CYC_N ##1 (dbus_o == CYC_I && !done_o)[*3] ##1 done_o) else $error("pc load not five cycles");
	stall_idle_a: assert property (fetch_stall_o |-> ibus_o == CYC_I) else $error("fetch during interlock");
	xfer_order_a: assert property (xfer_valid_o && $past(xfer_valid_o) && !$past(done_o)
		|-> xfer_reg_o > $past(xfer_reg_o)) else $error("transfer order not ascending");
	rs_select_a: assert property (mul_rs_o == (narrow_enc_i ? {1'b0, instr_i[2:0]} : instr_i[11:8]))
		else $error("multiplier operand register wrong");
	mul_len_a: assert property (done_o && mul_r |-> idx_r == exp_r) else $error("multiply length wrong");
endmodule : tci_core_properties

bind tci_core tci_core_properties i_props (.*);

// >>> tb/core_cycle_timing_interlock_bench.sv
// self-checking bench for the cycle timing and interlock sequencer
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin err_count++; $display("CHECK FAILED %s expected %0d seen %0d", nm, ex, got); end end

module core_cycle_timing_interlock_bench;
	import tci_pkg::*;
	// f bits: dep-on-r3, pc, shift, subword, used, flags, unsigned, narrow
	typedef struct {
		tci_class_e cls;
		logic [7:0] f;
		int         list, w, b, rs, t, st;
	} tci_row_s;
	logic        clk_i, rst_b_i, issue_valid_i, pc_dest_i, reg_shift_i, subword_i, flags_only_i, unsigned_i;
	logic        narrow_enc_i, next_uses_i, cp_busy_i, issue_ready_o, fetch_stall_o, xfer_valid_o, done_o, busy_o;
	logic [31:0] instr_i, mul_operand_i;
	logic [15:0] reg_list_i, next_src_i;
	logic [4:0]  cp_words_i;
	logic [3:0]  mul_rs_o, xfer_reg_o, busy_b, dn;
	logic [11:0] seq;
	tci_class_e  iclass_i;
	tci_cyc_e    ibus_o, dbus_o;
	int          err_count, cmp_count, n, s;
	tci_row_s rows [30] = '{
		'{CLS_DATA_OP, 8'h00, 0, 0, 0, 0, 1, 0},
		'{CLS_DATA_OP, 8'h20, 0, 0, 0, 0, 2, 0},
		'{CLS_DATA_OP, 8'h40, 0, 0, 0, 0, 3, 0},
		'{CLS_DATA_OP, 8'h60, 0, 0, 0, 0, 4, 0},
		'{CLS_SINGLE_LOAD, 8'h00, 0, 0, 0, 0, 1, 0},
		'{CLS_SINGLE_LOAD, 8'h08, 0, 0, 0, 0, 2, 1},
		'{CLS_SINGLE_LOAD, 8'h18, 0, 0, 0, 0, 3, 2},
		'{CLS_SINGLE_LOAD, 8'h40, 0, 0, 0, 0, 5, 0},
		'{CLS_SINGLE_STORE, 8'h00, 0, 0, 0, 0, 1, 0},
		'{CLS_LOAD_MULTIPLE, 8'h00, 2, 0, 0, 0, 2, 0},
		'{CLS_LOAD_MULTIPLE, 8'h00, 14, 0, 0, 0, 3, 0},
		'{CLS_LOAD_MULTIPLE, 8'h80, 14, 0, 0, 0, 4, 1},
		'{CLS_LOAD_MULTIPLE, 8'h00, 32774, 0, 0, 0, 7, 0},
		'{CLS_STORE_MULTIPLE, 8'h00, 2, 0, 0, 0, 2, 0},
		'{CLS_STORE_MULTIPLE, 8'h00, 240, 0, 0, 0, 4, 0},
		'{CLS_ATOMIC_SWAP, 8'h00, 0, 0, 0, 0, 2, 0},
		'{CLS_ATOMIC_SWAP, 8'h08, 0, 0, 0, 0, 3, 1},
		'{CLS_COPROC_DATA_OP, 8'h00, 0, 0, 2, 0, 3, 0},
		'{CLS_COPROC_LOAD_STORE, 8'h00, 0, 3, 1, 0, 4, 0},
		'{CLS_CORE_TO_COPROC_MOVE, 8'h00, 0, 0, 2, 0, 3, 0},
		'{CLS_COPROC_TO_CORE_MOVE, 8'h00, 0, 0, 1, 0, 2, 0},
		'{CLS_COPROC_TO_CORE_MOVE, 8'h08, 0, 0, 1, 0, 3, 1},
		'{CLS_COPROC_TO_CORE_MOVE, 8'h40, 0, 0, 1, 0, 4, 2},
		'{CLS_STATUS_REG_WRITE, 8'h04, 0, 0, 0, 0, 1, 0},
		'{CLS_STATUS_REG_WRITE, 8'h00, 0, 0, 0, 0, 3, 0},
		'{CLS_MULTIPLY_32, 8'h00, 0, 0, 0, 3, 5, 0},
		'{CLS_MULTIPLY_32, 8'h00, 0, 0, 0, 5, 4, 0},
		'{CLS_LONG_MULTIPLY, 8'h00, 0, 0, 0, 1, 4, 0},
		'{CLS_LONG_MULTIPLY, 8'h02, 0, 0, 0, 1, 7, 0},
		'{CLS_MULTIPLY_32, 8'h01, 0, 0, 0, 3, 5, 0}
	};

	tci_core i_dut (.*);
	tci_far_model i_far (.clk_i, .rst_b_i, .arm_i(issue_valid_i), .b_i(busy_b), .mul_rs_i(mul_rs_o),
		.cp_busy_o(cp_busy_i), .mul_operand_o(mul_operand_i));

	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	task automatic put(input tci_row_s r);
		iclass_i = r.cls;
		{pc_dest_i, reg_shift_i, subword_i, next_uses_i, flags_only_i, unsigned_i, narrow_enc_i} = r.f[6:0];
		next_src_i = {12'h000, r.f[7], 3'h0};
		reg_list_i = 16'(r.list);
		cp_words_i = 5'(r.w);
		busy_b = 4'(r.b);
		// the unused operand field names r6 (wide) or r4 (narrow), a different count in every row but the unsigned long one
		instr_i = r.f[0] ? {29'h0000400 >> 3, 3'(r.rs)} : {20'h00000, 4'(r.rs), 8'h06};
		issue_valid_i = 1'b1;
	endtask : put

	task automatic run(input tci_row_s r);
		put(r);
		@(posedge clk_i);
		#1 issue_valid_i = 1'b0;
		n = 1;
		s = int'(fetch_stall_o === 1'b1);
		if (xfer_valid_o === 1'b1)
			seq = {seq[7:0], xfer_reg_o};
		while (done_o !== 1'b1 && n < 40)
		begin
			@(posedge clk_i);
			#1 n++;
			s += int'(fetch_stall_o === 1'b1);
			if (xfer_valid_o === 1'b1)
				seq = {seq[7:0], xfer_reg_o};
		end
		`CHK("cycles", r.t, n)
		`CHK("stalls", r.st, s)
	endtask : run

	task automatic conclude();
		$display("mismatches %0d of %0d comparisons", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude

	initial
	begin
		err_count = 0;
		cmp_count = 0;
		rst_b_i = 1'b0;
		put(rows[0]);
		issue_valid_i = 1'b0;
		repeat (2) @(posedge clk_i);
		#1 `CHK("ready in reset", 1'b1, issue_ready_o)
		`CHK("busy in reset", 1'b0, busy_o)
		repeat (2) @(posedge clk_i);
		#1 rst_b_i = 1'b1;
		foreach (rows[i])
			run(rows[i]);
		// offer held high: the second op must wait for the first one's last cycle
		put(rows[1]);
		dn = 4'h0;
		repeat (4)
		begin
			@(posedge clk_i);
			#1 dn = {dn[2:0], done_o};
		end
		issue_valid_i = 1'b0;
		@(posedge clk_i);
		#1 `CHK("held offer done", 4'h5, dn)
		`CHK("idle after", 1'b0, busy_o)
		seq = 12'h000;
		run(rows[10]);
		`CHK("transfer order", 12'h123, seq)
		conclude();
	end

	initial
	begin
		#40000;
		err_count++;
		conclude();
	end
endmodule : core_cycle_timing_interlock_bench
